/* File: touch_threshold_sounder_info.sv */
// two-wire slave register bank: thresholds, sounder config, descriptor
`timescale 1ns/10ps
`default_nettype none
`include "touch_cfg.svh"
module touch_threshold_sounder_info
  import touch_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT,
  parameter int unsigned HALF_LOW = `HALF_LOW_CYC,
  parameter int unsigned HALF_HIGH = `HALF_HIGH_CYC,
  parameter int unsigned CLICK_SHORT = `CLICK_SHORT_CYC,
  parameter int unsigned CLICK_LONG = `CLICK_LONG_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic pad_touch_new,
  output logic [55:0] threshold_level,
  output logic sounder_out
);
  localparam logic [8*`DESC_LEN-1:0] DESC = `DESC_TEXT;
  localparam logic [4:0] DESC_END = 5'(`DESC_LEN);

  link_state_t state_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic rw_r;
  logic ack_ph_r;
  logic mack_r;
  logic [7:0] ptr_r;
  logic ptr_set_r;
  logic [4:0] char_idx_r;
  thr_code_t thr_r [8];
  logic [2:0] cfg_r;
  logic start_ev;
  logic stop_ev;
  logic rise;
  logic fall;
  logic [7:0] rx_byte;
  logic wr_en;
  logic rd_done;
  logic [7:0] rd_byte;

  // descriptor character, zero from the terminator onward
  function automatic logic [7:0] desc_byte(input logic [4:0] idx);
    if (idx >= DESC_END) begin
      return 8'h00;
    end
    return DESC[(`DESC_LEN - 1 - int'(idx)) * 8 +: 8];
  endfunction : desc_byte

  // threshold slot test; the sounder register shadows slot 3
  function automatic logic is_thr(input logic [7:0] a);
    return (a >= `REG_THR_FIRST) && (a <= `REG_THR_LAST) && (a != `REG_CLICK_CFG);
  endfunction : is_thr

  function automatic thr_code_t clamp(input logic [7:0] d);
    return (d > {2'h0, `THR_MAX_CODE}) ? `THR_MAX_CODE : d[5:0];
  endfunction : clamp

  // read decode; unmapped addresses answer zero
  always_comb begin
    if (ptr_r == `REG_INFO) begin
      rd_byte = desc_byte(char_idx_r);
    end else if (ptr_r == `REG_CLICK_CFG) begin
      rd_byte = {5'h00, cfg_r};
    end else if (is_thr(ptr_r)) begin
      rd_byte = {2'h0, thr_r[3'(ptr_r - `REG_THR_FIRST)]};
    end else begin
      rd_byte = 8'h00;
    end
  end

  // line condition detection on synchronous inputs
  assign start_ev = scl_in && scl_q_r && sda_q_r && !sda_in;
  assign stop_ev = scl_in && scl_q_r && !sda_q_r && sda_in;
  assign rise = scl_in && !scl_q_r;
  assign fall = !scl_in && scl_q_r;
  assign rx_byte = {shift_r[6:0], sda_in};
  assign wr_en = (state_r == ST_WREG) && rise && (bit_cnt_r == 3'h7) && ptr_set_r;
  assign rd_done = (state_r == ST_RDATA) && rise && (bit_cnt_r == 3'h7);
  assign sda_out = 1'b0; // open drain: only ever pulls low

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end

  // link state machine; sda only changes after scl falls
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      ack_ph_r <= 1'b0;
      mack_r <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_ev) begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 3'h0;
      ack_ph_r <= 1'b0;
      mack_r <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_ev) begin
      state_r <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_WREG: begin
          if (rise) begin
            shift_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7 && state_r == ST_WREG) begin
              state_r <= ST_ACK_W;
            end else if (bit_cnt_r == 3'h7 && rx_byte[7:1] == DEV_ADDR) begin
              rw_r <= rx_byte[0];
              state_r <= ST_ACK_A;
            end else if (bit_cnt_r == 3'h7) begin
              state_r <= ST_IDLE; // not our address
            end
          end
        end
        ST_ACK_A, ST_ACK_W: begin
          if (fall && !ack_ph_r) begin
            ack_ph_r <= 1'b1;
            sda_oe <= 1'b1;
          end else if (fall && state_r == ST_ACK_A && rw_r) begin
            ack_ph_r <= 1'b0;
            state_r <= ST_RDATA;
            tx_r <= rd_byte;
            sda_oe <= ~rd_byte[7];
          end else if (fall) begin
            ack_ph_r <= 1'b0;
            state_r <= ST_WREG;
            sda_oe <= 1'b0;
          end
        end
        ST_RDATA: begin
          if (rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              state_r <= ST_RACK;
            end
          end else if (fall) begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe <= ~tx_r[6];
          end
        end
        ST_RACK: begin
          if (rise && !sda_in) begin
            mack_r <= 1'b1;
          end else if (rise) begin
            state_r <= ST_IDLE; // master nack ends the burst
          end else if (fall && mack_r) begin
            mack_r <= 1'b0;
            state_r <= ST_RDATA;
            tx_r <= rd_byte;
            sda_oe <= ~rd_byte[7];
          end else if (fall) begin
            sda_oe <= 1'b0;
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // register pointer: first written byte, then auto-increment, except on reads of the descriptor address
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_r <= 8'h00;
      ptr_set_r <= 1'b0;
    end else if (start_ev) begin
      ptr_set_r <= 1'b0;
    end else if ((state_r == ST_WREG) && rise && (bit_cnt_r == 3'h7) && !ptr_set_r) begin
      ptr_r <= rx_byte;
      ptr_set_r <= 1'b1;
    end else if (wr_en || (rd_done && ptr_r != `REG_INFO)) begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || start_ev) begin
      char_idx_r <= 5'h00;
    end else if (rd_done && ptr_r == `REG_INFO && char_idx_r < DESC_END) begin
      char_idx_r <= char_idx_r + 5'h01;
    end
  end

  // descriptor address has no write path
  always_ff @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (!rst_b) begin
        thr_r[i] <= `THR_RESET;
      end else if (wr_en && is_thr(ptr_r) && 3'(ptr_r - `REG_THR_FIRST) == 3'(i)) begin
        thr_r[i] <= clamp(rx_byte);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_r <= `CFG_RESET;
    end else if (wr_en && ptr_r == `REG_CLICK_CFG) begin
      cfg_r <= rx_byte[2:0];
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      threshold_level[i*7 +: 7] = {1'b0, thr_r[i]} + 7'h01;
    end
  end

  click_sounder #(
    .HALF_LOW(HALF_LOW),
    .HALF_HIGH(HALF_HIGH),
    .CLICK_SHORT(CLICK_SHORT),
    .CLICK_LONG(CLICK_LONG)
  ) u_click (
    .clk(clk),
    .rst_b(rst_b),
    .click_output_on(cfg_r[`CFG_ON_BIT]),
    .tone_pitch_sel(cfg_r[`CFG_PITCH_BIT]),
    .click_length_sel(cfg_r[`CFG_LEN_BIT]),
    .pad_touch_new(pad_touch_new),
    .sounder_out(sounder_out)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_bank_read;
    $rose(state_r == ST_RDATA) && is_thr(ptr_r) |-> tx_r == {2'h0, thr_r[3'(ptr_r - `REG_THR_FIRST)]};
  endproperty
  a_bank_read: assert property (p_bank_read) else $error("threshold readback wrong");
  property p_level;
    wr_en && ptr_r == `REG_THR_FIRST && rx_byte < 8'h40 |=> threshold_level[6:0] == $past(rx_byte[6:0]) + 7'h01;
  endproperty
  a_level: assert property (p_level) else $error("level not code plus one");
  property p_clamp;
    wr_en && is_thr(ptr_r) && rx_byte > 8'h3F |=>
      threshold_level[7 * $past(3'(ptr_r - `REG_THR_FIRST)) +: 7] == 7'h40;
  endproperty
  a_clamp: assert property (p_clamp) else $error("out of range not clamped");
  property p_info_ro;
    wr_en && ptr_r == `REG_INFO |=> $stable(cfg_r) && $stable(threshold_level);
  endproperty
  a_info_ro: assert property (p_info_ro) else $error("descriptor write had effect");
  property p_desc;
    $rose(state_r == ST_RDATA) && ptr_r == `REG_INFO |-> tx_r == desc_byte(char_idx_r);
  endproperty
  a_desc: assert property (p_desc) else $error("descriptor byte wrong");
  property p_restart;
    start_ev |=> char_idx_r == 5'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("char pointer not restarted");
  property p_advance;
    rd_done && ptr_r == `REG_INFO && char_idx_r < DESC_END |=> char_idx_r == $past(char_idx_r) + 5'h01;
  endproperty
  a_advance: assert property (p_advance) else $error("char pointer did not advance");
  c_info_burst: cover property (rd_done && ptr_r == `REG_INFO && char_idx_r == DESC_END);
  c_clamp: cover property (wr_en && is_thr(ptr_r) && rx_byte > 8'h3F);
  c_cfg_write: cover property (wr_en && ptr_r == `REG_CLICK_CFG);
endmodule : touch_threshold_sounder_info
`default_nettype wire

/* File: touch_cfg.svh */
// constants for the touch threshold, click sounder and descriptor register block
`ifndef TOUCH_CFG_SVH
`define TOUCH_CFG_SVH

// register map
`define REG_THR_FIRST 8'h04
`define REG_THR_LAST 8'h0B
`define REG_CLICK_CFG 8'h07
`define REG_INFO 8'h14

// field layout and reset values
`define THR_MAX_CODE 6'h3F
`define THR_RESET 6'h0F
`define CFG_ON_BIT 0
`define CFG_PITCH_BIT 1
`define CFG_LEN_BIT 2
`define CFG_RESET 3'h0

// bus address of the device on the two-wire link
`define DEV_ADDR_DEFAULT 7'h2A

// descriptor text, terminator appended by hardware
`define DESC_TEXT "XV,PN:TS8,QUAL:ES,VER:1_0_0"
`define DESC_LEN 27

// timing: figures in their own units, then cycle counts
`define CLK_HZ 250000000
`define TONE_LOW_HZ 1000
`define TONE_HIGH_HZ 2000
`define CLICK_SHORT_MS 10
`define CLICK_LONG_MS 20
`define HALF_LOW_CYC (`CLK_HZ / (2 * `TONE_LOW_HZ))
`define HALF_HIGH_CYC (`CLK_HZ / (2 * `TONE_HIGH_HZ))
`define CLICK_SHORT_CYC (`CLK_HZ / 1000 * `CLICK_SHORT_MS)
`define CLICK_LONG_CYC (`CLK_HZ / 1000 * `CLICK_LONG_MS)

`endif

/* File: touch_pkg.sv */
// types shared by the touch register block
package touch_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK_A = 3'h2,
    ST_WREG = 3'h3,
    ST_ACK_W = 3'h4,
    ST_RDATA = 3'h5,
    ST_RACK = 3'h6
  } link_state_t;
  typedef logic [5:0] thr_code_t;
endpackage : touch_pkg

/* File: click_sounder.sv */
// key-click tone generator for the piezo output
`timescale 1ns/10ps
`default_nettype none
`include "touch_cfg.svh"
module click_sounder #(
  parameter int unsigned HALF_LOW = `HALF_LOW_CYC,
  parameter int unsigned HALF_HIGH = `HALF_HIGH_CYC,
  parameter int unsigned CLICK_SHORT = `CLICK_SHORT_CYC,
  parameter int unsigned CLICK_LONG = `CLICK_LONG_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic click_output_on,
  input wire logic tone_pitch_sel,
  input wire logic click_length_sel,
  input wire logic pad_touch_new,
  output logic sounder_out
);
  logic busy_r;
  logic [22:0] len_cnt_r;
  logic [22:0] tone_cnt_r;
  logic [22:0] len_end;
  logic [22:0] half_end;

  assign half_end = tone_pitch_sel ? 23'(HALF_HIGH - 1) : 23'(HALF_LOW - 1);
  assign len_end = click_length_sel ? 23'(CLICK_LONG - 1) : 23'(CLICK_SHORT - 1);

  // click burst timer
  // touches during a click are ignored, not queued
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
      len_cnt_r <= 23'h0;
    end else if (!click_output_on) begin
      busy_r <= 1'b0;
      len_cnt_r <= 23'h0;
    end else if (!busy_r) begin
      busy_r <= pad_touch_new;
      len_cnt_r <= 23'h0;
    end else if (len_cnt_r == len_end) begin
      busy_r <= 1'b0;
    end else begin
      len_cnt_r <= len_cnt_r + 23'h1;
    end
  end

  // square wave, held low and restarted at each click
  // no dependence on link state so clicks work with the bus idle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tone_cnt_r <= 23'h0;
      sounder_out <= 1'b0;
    end else if (!busy_r || !click_output_on) begin
      tone_cnt_r <= 23'h0;
      sounder_out <= 1'b0; // piezo rests low between clicks
    end else if (tone_cnt_r == half_end) begin
      tone_cnt_r <= 23'h0;
      sounder_out <= ~sounder_out;
    end else begin
      tone_cnt_r <= tone_cnt_r + 23'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_gate;
    !click_output_on |=> !sounder_out;
  endproperty
  a_gate: assert property (p_gate) else $error("sounder drove while disabled");
  property p_pitch;
    $changed(sounder_out) && $past(busy_r) && $past(click_output_on) |-> $past(tone_cnt_r) == $past(half_end);
  endproperty
  a_pitch: assert property (p_pitch) else $error("tone half period wrong");
  property p_len;
    $fell(busy_r) && $past(click_output_on) |-> $past(len_cnt_r) == $past(len_end);
  endproperty
  a_len: assert property (p_len) else $error("click length wrong");
  property p_start;
    !busy_r && click_output_on && pad_touch_new |=> busy_r;
  endproperty
  a_start: assert property (p_start) else $error("touch did not start click");
  property p_idle;
    !busy_r |=> !sounder_out;
  endproperty
  a_idle: assert property (p_idle) else $error("sounder not idle after click");
  c_click: cover property ($fell(busy_r) && $past(click_output_on));
endmodule : click_sounder
`default_nettype wire

/* File: bus_host_model.sv */
// two-wire bus master model standing in for the host controller
`timescale 1ns/10ps
`default_nettype none
module bus_host_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // bus idles released; the pull-up makes both lines high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // every phase lasts 4 clocks, above the 3 the slave needs
  task automatic hold();
    repeat (4) @(negedge clk);
  endtask : hold
  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sda_drv = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_drv = 1'b0;
    hold();
    scl = 1'b0;
  endtask : start_cond
  // data moves one clock after the clock fall, never with it
  task automatic bit_io(input logic b, output logic got);
    @(negedge clk);
    sda_drv = b;
    hold();
    scl = 1'b1;
    hold();
    got = sda_line;
    scl = 1'b0;
  endtask : bit_io
  // byte out msb first, then sample the slave's acknowledge
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(v[i], g);
    bit_io(1'b1, g);
    ack = ~g;
  endtask : put_byte
  // byte in with the line released, then our acknowledge
  task automatic get_byte(input logic nack, output logic [7:0] v);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(nack, g);
  endtask : get_byte
  // stop: data rises while the clock is high
  task automatic stop_cond();
    @(negedge clk);
    sda_drv = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_drv = 1'b1;
    hold();
  endtask : stop_cond
endmodule : bus_host_model
`default_nettype wire

/* File: touch_threshold_sounder_info_test.sv */
// self-checking bench for the threshold, sounder and descriptor block
`timescale 1ns/10ps
`default_nettype none
`include "touch_cfg.svh"
module touch_threshold_sounder_info_test;
  import touch_pkg::*;
  localparam int HL = 10;
  localparam int HH = 5;
  localparam int CS = 100;
  localparam int CL = 200;
  localparam logic [6:0] ADR = `DEV_ADDR_DEFAULT;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pad_touch_new = 1'b0;
  logic scl;
  logic sda_drv;
  logic sda_out;
  logic sda_oe;
  logic sda_in;
  logic sounder_out;
  logic [55:0] threshold_level;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  // open-drain wire with pull-up, low if either side pulls
  assign sda_in = (sda_oe ? sda_out : 1'b1) & sda_drv;
  always #2 clk = ~clk;
  // hang guard, about three times the roughly 13000 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end
  bus_host_model host (.clk(clk), .sda_line(sda_in), .scl(scl), .sda_drv(sda_drv));
  touch_threshold_sounder_info #(.HALF_LOW(HL), .HALF_HIGH(HH), .CLICK_SHORT(CS), .CLICK_LONG(CL)) dut (
    .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .pad_touch_new(pad_touch_new), .threshold_level(threshold_level), .sounder_out(sounder_out));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    logic k0, k1, k2;
    host.start_cond();
    host.put_byte({ADR, 1'b0}, k0);
    host.put_byte(a, k1);
    host.put_byte(d, k2);
    host.stop_cond();
    check({k0, k1, k2}, 3'b111);
  endtask : reg_write
  // pointer set by a write, then a repeated start to read one byte
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    logic k0, k1, k2;
    host.start_cond();
    host.put_byte({ADR, 1'b0}, k0);
    host.put_byte(a, k1);
    host.start_cond();
    host.put_byte({ADR, 1'b1}, k2);
    host.get_byte(1'b1, d);
    host.stop_cond();
    check({k0, k1, k2}, 3'b111);
  endtask : reg_read
  // reset levels, idle outputs, foreign address refused
  task automatic t_reset();
    logic [7:0] d;
    logic k;
    check(threshold_level, {8{7'h10}});
    check({sounder_out, sda_oe, sda_out}, 3'b000);
    reg_read(8'h07, d);
    check(d, 8'h00);
    reg_read(8'h20, d);
    check(d, 8'h00);
    host.start_cond();
    host.put_byte({ADR ^ 7'h01, 1'b0}, k);
    host.stop_cond();
    check(k, 1'b0);
  endtask : t_reset
  // one click per touch; a second touch mid-click must not stretch it
  task automatic t_click(input logic [2:0] cfg);
    int half, len, rise, fall, last, highs;
    logic [7:0] d;
    half = cfg[1] ? HH : HL;
    len = cfg[2] ? CL : CS;
    rise = -1;
    fall = -1;
    last = -1;
    highs = 0;
    reg_write(8'h07, {5'h00, cfg});
    reg_read(8'h07, d);
    check(d, {5'h00, cfg});
    @(negedge clk) pad_touch_new = 1'b1;
    @(negedge clk) pad_touch_new = 1'b0;
    for (int t = 0; t < CL + 40; t++) begin
      @(negedge clk);
      pad_touch_new = (t == len / 2);
      if (sounder_out === 1'b1) begin
        highs++;
        last = t;
        if (rise < 0) rise = t;
      end else if (rise >= 0 && fall < 0) fall = t;
    end
    if (!cfg[0]) check(highs, 0);
    else begin
      check(fall - rise, half);
      check(last <= len + 2 && last >= len - 2 * half, 1);
      check(highs >= len / 2 - half && highs <= len / 2 + half, 1);
    end
  endtask : t_click
  // codes above 63 clamp; slot 3 is shadowed by the sounder register
  task automatic t_thresh();
    logic [7:0] v [8] = '{8'h00, 8'h3F, 8'h40, 8'h00, 8'hFF, 8'h20, 8'h01, 8'h3E};
    logic [7:0] d;
    logic [6:0] e;
    for (int i = 0; i < 8; i++) begin
      if (i != 3) begin
        e = (v[i] > 8'h3F) ? 7'h40 : v[i][6:0] + 7'h01;
        reg_write(8'h04 + i[7:0], v[i]);
        reg_read(8'h04 + i[7:0], d);
        check(d, e - 7'h01);
        check(threshold_level[7 * i +: 7], e);
      end
    end
    check(threshold_level[27:21], 7'h10);
  endtask : t_thresh
  // burst read of the descriptor, ignored write, restart per transaction
  task automatic t_info();
    string s = `DESC_TEXT;
    logic [7:0] d;
    logic k0, k1, k2;
    reg_write(8'h14, 8'hFF);
    host.start_cond();
    host.put_byte({ADR, 1'b0}, k0);
    host.put_byte(8'h14, k1);
    host.start_cond();
    host.put_byte({ADR, 1'b1}, k2);
    for (int i = 0; i <= `DESC_LEN; i++) begin
      // host ends with a not-acknowledge at the terminator
      host.get_byte(i == `DESC_LEN, d);
      check(d, (i < `DESC_LEN) ? s[i] : 8'h00);
    end
    host.stop_cond();
    check({k0, k1, k2}, 3'b111);
    reg_read(8'h14, d);
    check(d, s[0]);
  endtask : t_info
  task automatic close_out();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // main sequence; clicks run with the bus idle, touches alone start them
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_click(3'h6);
    t_click(3'h1);
    t_click(3'h3);
    t_click(3'h5);
    t_click(3'h7);
    t_thresh();
    t_info();
    close_out();
  end
endmodule : touch_threshold_sounder_info_test
`default_nettype wire
